// ===== inc/see_map.svh
// Purpose: Constants for the serial EEPROM target: sizes, bus codes, timing.
// Assumes: Included by the package and by the memory and target design files.
// Notes:   Guarded against double inclusion; definitions only.
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

// Array geometry
`define SEE_MEM_BYTES    4096
`define SEE_ADDR_W       12
`define SEE_PAGE_BYTES   32
`define SEE_PAGE_W       5
`define SEE_PAGE_MASK    12'h01F
`define SEE_ARRAY_MASK   12'hFFF
`define SEE_SN_MASK      12'h00F
`define SEE_SN_BYTES     16

// Bus type codes in the upper nibble of the select byte
`define SEE_TYPE_ARRAY   4'hA
`define SEE_TYPE_SERIAL  4'hB

// Serial number default; value is arbitrary
`define SEE_SN_RESET     128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210

// Bits in one byte on the wire
`define SEE_BYTE_BITS    4'h8

// Timing: system clock period and longest self-timed write
`define SEE_CLK_NS       100
`define SEE_T_WR_NS      5000000
`define SEE_T_WR_CYC     (`SEE_T_WR_NS / `SEE_CLK_NS)

`endif

// ===== inc/see_pkg.sv
// Purpose: Types shared by the serial EEPROM target modules.
// Assumes: see_map.svh supplies the widths.
// Notes:   States are one-hot; the push struct carries one page byte.
`include "see_map.svh"

package see_pkg;

	typedef logic [`SEE_ADDR_W-1:0] see_addr_t;
	typedef logic [7:0]             see_byte_t;

	// Link engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_RACK = 5'h10
	} see_state_e;

	// Meaning of the next received byte
	typedef enum logic [1:0] {
		BK_DEV  = 2'h0,
		BK_AHI  = 2'h1,
		BK_ALO  = 2'h2,
		BK_DATA = 2'h3
	} see_kind_e;

	// One byte headed for the page latch
	typedef struct packed {
		logic                   vld;
		logic [`SEE_PAGE_W-1:0] off;
		see_byte_t              data;
	} see_push_s;

endpackage

// ===== src/see_sync.sv
// Purpose: Two-flop synchroniser for pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second stage may be read by logic.
`timescale 1ns/1ns
`default_nettype none

module see_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,  // System clock
	input  wire logic         rst,  // Synchronous reset
	input  wire logic [W-1:0] d,    // Raw pin levels
	output logic      [W-1:0] q     // Synchronised levels
);

	logic [W-1:0] meta_r;

	// Meta stage feeds only the output stage
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ===== src/see_mem.sv
// Purpose: User array, page latch and self-timed programming cycle.
// Assumes: Pushes only arrive while not busy; TWR is at least PAGE.
// Notes:   Programming copies latched bytes one per cycle, then waits out the rest of TWR.
`timescale 1ns/1ns
`default_nettype none
`include "see_map.svh"

module see_mem
	import see_pkg::*;
#(
	parameter int unsigned DEPTH = `SEE_MEM_BYTES,
	parameter int unsigned PAGE  = `SEE_PAGE_BYTES,
	parameter int unsigned TWR   = `SEE_T_WR_CYC
) (
	input  wire logic                                clk,     // System clock
	input  wire logic                                rst,     // Synchronous reset
	input  wire see_push_s                           push,    // Byte for page latch
	input  wire logic [$clog2(DEPTH)-$clog2(PAGE)-1:0] page,  // Page of pushed byte
	input  wire logic                                clr,     // Drop latched bytes
	input  wire logic                                commit,  // Start programming
	input  wire logic [$clog2(DEPTH)-1:0]            rd_addr, // Read address
	output see_byte_t                                rd_data, // Read data
	output logic                                     busy     // Write cycle running
);

	localparam int AW = $clog2(DEPTH);
	localparam int PW = $clog2(PAGE);
	localparam int CW = $clog2(TWR + 1);

	see_byte_t         arr_r  [DEPTH];
	see_byte_t         page_r [PAGE];
	logic [PAGE-1:0]   vmask_r;
	logic [AW-PW-1:0]  base_r;
	logic [CW-1:0]     cnt_r;
	logic              busy_r;
	logic [PW-1:0]     prog_idx;
	logic              prog_we;

	// Copy phase uses the first PAGE counts of the timed cycle
	assign prog_idx = cnt_r[PW-1:0];
	assign prog_we  = busy_r && (cnt_r < CW'(PAGE)) && vmask_r[prog_idx];
	assign rd_data  = arr_r[rd_addr];
	assign busy     = busy_r;

	// Write cycle control; busy ends exactly TWR cycles after commit
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_r  <= 1'b0;
			cnt_r   <= '0;
			vmask_r <= '0;
			base_r  <= '0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + CW'(1);
			if (cnt_r == CW'(TWR - 1)) begin
				busy_r  <= 1'b0;
				vmask_r <= '0;
			end
		end else if (commit && (|vmask_r)) begin
			busy_r <= 1'b1;
			cnt_r  <= '0;
		end else if (clr) begin
			vmask_r <= '0;
		end else if (push.vld) begin
			vmask_r[push.off] <= 1'b1;
			base_r            <= page;
		end
	end

	// Storage without reset: contents survive like nonvolatile cells
	always_ff @(posedge clk) begin
		if (!busy_r && push.vld) begin
			page_r[push.off] <= push.data;
		end
		if (prog_we) begin
			arr_r[{base_r, prog_idx}] <= page_r[prog_idx];
		end
	end

endmodule

`default_nettype wire

// ===== src/see_i2c_target.sv
// Purpose: Two-wire serial EEPROM target with a read-only serial number.
// Assumes: SCL and SDA are slow against CLK; pins arrive asynchronously.
// Notes:   SDA is open drain: SDA_OUT stays low, SDA_OE pulls the line.
`timescale 1ns/1ns
`default_nettype none
`include "see_map.svh"

// Functional notes
// - 4096-byte user array, serially addressable
// - fixed 128-bit serial number, readable, never written
// - serial number stored apart from user array
// - page writes up to 32 bytes, partial allowed
// - self-timed write finishes within 5 ms
// - random and sequential reads supported
// - three address pins form bus identity
// - respond only when address bits match pins
// - undriven address and protect pins read low
// - SDA driven low or released only
// - sample SDA on SCL rising edge
// - change SDA output only after SCL falls
// - protect pin high blocks all array writes
module see_i2c_target
	import see_pkg::*;
#(
	parameter int unsigned   TWR_CYC       = `SEE_T_WR_CYC, // Write cycle length
	parameter logic [127:0] SERIAL_NUMBER = `SEE_SN_RESET   // Value is arbitrary
) (
	input  wire logic CLK,              // System clock, 10 MHz
	input  wire logic RESET,            // Synchronous reset, active high
	input  wire logic SCL,              // Serial clock pin
	input  wire logic SDA_IN,           // Serial data pin level
	output logic      SDA_OUT,          // Serial data drive value, always low
	output logic      SDA_OE,           // High while pulling SDA low
	input  wire logic ADDR_SELECT_BIT0, // Bus identity pin 0
	input  wire logic ADDR_SELECT_BIT1, // Bus identity pin 1
	input  wire logic ADDR_SELECT_BIT2, // Bus identity pin 2
	input  wire logic WRITE_PROTECT,    // High blocks array writes
	output logic      BUSY              // Internal write cycle running
);

	logic [5:0]  pins_s;
	logic        scl_s;
	logic        sda_s;
	logic [2:0]  sel_s;
	logic        wp_s;
	logic        scl_d_r;
	logic        sda_d_r;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;

	see_state_e  state_r,  state_nxt;
	see_kind_e   kind_r,   kind_nxt;
	logic [3:0]  bitcnt_r, bitcnt_nxt;
	see_byte_t   shift_r,  shift_nxt;
	see_byte_t   tx_r,     tx_nxt;
	see_addr_t   addr_r,   addr_nxt;
	logic        sn_r,     sn_nxt;
	logic        rw_r,     rw_nxt;
	logic        ack_r,    ack_nxt;
	logic        mack_r,   mack_nxt;
	logic        oe_r,     oe_nxt;
	logic        busy_r;
	logic        sda_out_r;

	logic        mem_busy;
	see_byte_t   mem_data;
	see_byte_t   rd_byte;
	logic        dev_match;
	logic        dev_is_sn;
	logic        data_ok;
	logic        byte_ack;
	logic        byte_done;
	see_push_s   push_w;
	logic        commit_w;

	// Serial number byte; index 0 is the most significant byte
	function automatic see_byte_t sn_byte(input logic [3:0] idx);
		sn_byte = SERIAL_NUMBER[8 * (`SEE_SN_BYTES - 1 - int'(idx)) +: 8];
	endfunction

	// Address step that wraps inside the field given by mask
	function automatic see_addr_t addr_step(input see_addr_t a, input see_addr_t mask);
		addr_step = (a & ~mask) | ((a + see_addr_t'(1)) & mask);
	endfunction

	// Floating pins are pulled down at the pad, so they arrive here low
	see_sync #(
		.W (6)
	) u_sync (
		.clk (CLK),
		.rst (RESET),
		.d   ({WRITE_PROTECT, ADDR_SELECT_BIT2, ADDR_SELECT_BIT1,
		       ADDR_SELECT_BIT0, SDA_IN, SCL}),
		.q   (pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign sel_s = pins_s[4:2];
	assign wp_s  = pins_s[5];

	// Edge and condition detection on the synchronised lines
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// Select byte decode; a busy part stays silent for ack polling
	assign dev_is_sn = shift_r[7:4] == `SEE_TYPE_SERIAL;
	assign dev_match = (shift_r[3:1] == sel_s) && !mem_busy
	                   && (dev_is_sn || shift_r[7:4] == `SEE_TYPE_ARRAY);

	// Data bytes are refused for the serial space or under protect
	assign data_ok   = !sn_r && !wp_s && !mem_busy;
	assign byte_ack  = (kind_r == BK_DEV)  ? dev_match :
	                   (kind_r == BK_DATA) ? data_ok   : 1'b1;
	assign byte_done = (state_r == ST_RX) && scl_fall && (bitcnt_r == `SEE_BYTE_BITS);

	// Read source: serial number store is separate from the array
	assign rd_byte = sn_r ? sn_byte(addr_r[3:0]) : mem_data;

	// Accepted data byte goes to the page latch at its page offset
	assign push_w.vld  = byte_done && (kind_r == BK_DATA) && data_ok;
	assign push_w.off  = addr_r[`SEE_PAGE_W-1:0];
	assign push_w.data = shift_r;

	// Programming starts only at a stop with protect low
	assign commit_w = stop_det && !wp_s;

	see_mem #(
		.DEPTH (`SEE_MEM_BYTES),
		.PAGE  (`SEE_PAGE_BYTES),
		.TWR   (TWR_CYC)
	) u_mem (
		.clk     (CLK),
		.rst     (RESET),
		.push    (push_w),
		.page    (addr_r[`SEE_ADDR_W-1:`SEE_PAGE_W]),
		.clr     (start_det),
		.commit  (commit_w),
		.rd_addr (addr_r),
		.rd_data (mem_data),
		.busy    (mem_busy)
	);

	// Link engine next state
	always_comb begin
		state_nxt  = state_r;
		kind_nxt   = kind_r;
		bitcnt_nxt = bitcnt_r;
		shift_nxt  = shift_r;
		tx_nxt     = tx_r;
		addr_nxt   = addr_r;
		sn_nxt     = sn_r;
		rw_nxt     = rw_r;
		ack_nxt    = ack_r;
		mack_nxt   = mack_r;
		oe_nxt     = oe_r;
		if (start_det) begin
			// Start, including repeated start, always reopens addressing
			state_nxt  = ST_RX;
			kind_nxt   = BK_DEV;
			bitcnt_nxt = 4'h0;
			rw_nxt     = 1'b0;
			oe_nxt     = 1'b0;
		end else if (stop_det) begin
			state_nxt = ST_IDLE;
			oe_nxt    = 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					// Wait for a start; SCL is held high between frames
					oe_nxt = 1'b0;
				end
				ST_RX: begin
					if (scl_rise && bitcnt_r != `SEE_BYTE_BITS) begin
						shift_nxt  = {shift_r[6:0], sda_s};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end
					if (byte_done) begin
						state_nxt = ST_ACK;
						ack_nxt   = byte_ack;
						oe_nxt    = byte_ack;
						unique case (kind_r)
							BK_DEV: begin
								rw_nxt   = shift_r[0];
								sn_nxt   = dev_is_sn;
								kind_nxt = BK_AHI;
							end
							BK_AHI: begin
								addr_nxt[11:8] = shift_r[3:0];
								kind_nxt       = BK_ALO;
							end
							BK_ALO: begin
								addr_nxt[7:0] = shift_r;
								kind_nxt      = BK_DATA;
							end
							BK_DATA: begin
								// Roll over inside the page, never past it
								if (data_ok) begin
									addr_nxt = addr_step(addr_r, `SEE_PAGE_MASK);
								end
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bitcnt_nxt = 4'h0;
						if (!ack_r) begin
							state_nxt = ST_IDLE;
							oe_nxt    = 1'b0;
						end else if (rw_r) begin
							state_nxt = ST_TX;
							tx_nxt    = rd_byte;
							oe_nxt    = ~rd_byte[7];
						end else begin
							state_nxt = ST_RX;
							oe_nxt    = 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bitcnt_nxt = bitcnt_r + 4'h1;
					end
					if (scl_fall) begin
						if (bitcnt_r == `SEE_BYTE_BITS) begin
							// Byte sent: release for the controller's answer
							state_nxt = ST_RACK;
							oe_nxt    = 1'b0;
							addr_nxt  = addr_step(addr_r,
							            sn_r ? `SEE_SN_MASK : `SEE_ARRAY_MASK);
						end else begin
							tx_nxt = {tx_r[6:0], 1'b0};
							oe_nxt = ~tx_r[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_s;
					end
					if (scl_fall) begin
						bitcnt_nxt = 4'h0;
						if (mack_r) begin
							// Sequential read continues with the next byte
							state_nxt = ST_TX;
							tx_nxt    = rd_byte;
							oe_nxt    = ~rd_byte[7];
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
				default: begin
					state_nxt = ST_IDLE;
					oe_nxt    = 1'b0;
				end
			endcase
		end
	end

	// Line history for edge detection
	always_ff @(posedge CLK) begin
		if (RESET) begin
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end

	// Engine registers
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_r  <= ST_IDLE;
			kind_r   <= BK_DEV;
			bitcnt_r <= 4'h0;
			shift_r  <= 8'h00;
			tx_r     <= 8'h00;
			addr_r   <= '0;
			sn_r     <= 1'b0;
			rw_r     <= 1'b0;
			ack_r    <= 1'b0;
			mack_r   <= 1'b0;
			oe_r     <= 1'b0;
		end else begin
			state_r  <= state_nxt;
			kind_r   <= kind_nxt;
			bitcnt_r <= bitcnt_nxt;
			shift_r  <= shift_nxt;
			tx_r     <= tx_nxt;
			addr_r   <= addr_nxt;
			sn_r     <= sn_nxt;
			rw_r     <= rw_nxt;
			ack_r    <= ack_nxt;
			mack_r   <= mack_nxt;
			oe_r     <= oe_nxt;
		end
	end

	// Pin outputs from flops; the line is never driven high
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sda_out_r <= 1'b0;
			busy_r    <= 1'b0;
		end else begin
			sda_out_r <= 1'b0;
			busy_r    <= mem_busy;
		end
	end

	assign SDA_OUT = sda_out_r;
	assign SDA_OE  = oe_r;
	assign BUSY    = busy_r;

endmodule

`default_nettype wire

// ===== tb/see_ctl_model.sv
// Purpose: Behavioural two-wire bus controller facing the EEPROM target.
// Assumes: The bench calls its tasks one at a time.
// Notes:   Quarter bit is 200 ns, so SCL runs at 800 ns per bit.
`timescale 1ns/1ns
`default_nettype none

module see_ctl_model
	import see_pkg::*;
(
	output logic      scl,    // Serial clock, parked high
	output logic      sda_oe, // High pulls SDA low
	input  wire logic sda     // Resolved SDA level
);
	localparam int Q = 200;

	// Idle bus: clock parked high, data released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// One bit; data is only pulled low or released
	task automatic bit_x(input logic b, output logic r);
		#Q sda_oe = ~b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
	endtask

	// Start or repeated start; long wait lets the target drop its ack first
	task automatic start();
		sda_oe = 1'b0;
		#(3*Q) scl = 1'b1;
		#(2*Q) sda_oe = 1'b1;
		#(2*Q) scl = 1'b0;
	endtask

	// Stop leaves the clock high for the idle bus
	task automatic stop();
		#Q sda_oe = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_oe = 1'b0;
		#(2*Q);
	endtask

	task automatic byte_w(input see_byte_t d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = ~r;
	endtask

	// Not acknowledging the last byte ends a read
	task automatic byte_r(input logic last, output see_byte_t d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
endmodule
`default_nettype wire

// ===== tb/see_i2c_target_properties.sv
// Purpose: Port-level assertions for the serial EEPROM target.
// Assumes: Sees only the top ports; pins arrive asynchronously.
// Notes:   Edge counters saturate, so long idle stretches are harmless.
`timescale 1ns/1ns
`default_nettype none

module see_i2c_target_properties #(
	parameter int unsigned TWR_CYC = 50000 // Write cycle length
) (
	input wire logic CLK,           // System clock
	input wire logic RESET,         // Synchronous reset
	input wire logic SCL,           // Serial clock pin
	input wire logic SDA_IN,        // Resolved data line
	input wire logic SDA_OUT,       // Drive value
	input wire logic SDA_OE,        // Pull enable
	input wire logic WRITE_PROTECT, // Protect pin
	input wire logic BUSY           // Write cycle running
);
	logic        scl_r;
	logic        sda_r;
	logic [3:0]  fall_cnt_r;
	logic [3:0]  stop_cnt_r;
	logic [15:0] busy_cnt_r;

	// Raw pin edges; cycles since the last clock fall and the last stop
	wire logic       scl_fall_w   = scl_r & ~SCL;
	wire logic       stop_w       = scl_r & SCL & ~sda_r & SDA_IN;
	wire logic [3:0] fall_cnt_nxt = scl_fall_w ? 4'h0 : fall_cnt_r + 4'(fall_cnt_r != 4'hF);
	wire logic [3:0] stop_cnt_nxt = stop_w ? 4'h0 : stop_cnt_r + 4'(stop_cnt_r != 4'hF);

	always_ff @(posedge CLK) begin
		scl_r <= SCL;
		sda_r <= SDA_IN;
		fall_cnt_r <= RESET ? 4'hF : fall_cnt_nxt;
		stop_cnt_r <= RESET ? 4'hF : stop_cnt_nxt;
		busy_cnt_r <= BUSY ? busy_cnt_r + 16'h1 : 16'h0;
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);

	chk_drive_low: assert property (!SDA_OUT)
		else $error("SDA drive value is not low");
	chk_oe_after_fall: assert property ($changed(SDA_OE) |-> fall_cnt_r <= 4'h6)
		else $error("SDA drive changed away from a clock fall");
	chk_oe_steady_high: assert property (SCL && $past(SCL) && $past(SCL, 2) |-> $stable(SDA_OE))
		else $error("SDA drive changed while clock high");
	chk_quiet_busy: assert property (BUSY |-> !SDA_OE)
		else $error("Target answered during write cycle");
	chk_busy_len: assert property ($fell(BUSY) |-> busy_cnt_r >= TWR_CYC - 8 && busy_cnt_r <= TWR_CYC)
		else $error("Write cycle length out of bounds");
	chk_busy_cause: assert property ($rose(BUSY) |-> stop_cnt_r <= 4'h6)
		else $error("Write cycle began without a stop");
	chk_wp_hold: assert property ($rose(BUSY) |-> !$past(WRITE_PROTECT, 4))
		else $error("Write cycle began while protected");
	chk_oe_stand: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
		else $error("SDA pull shorter than a bit");

	cover property ($rose(BUSY));
	cover property ($fell(BUSY));
	cover property (WRITE_PROTECT && stop_w);
	cover property ($rose(SDA_OE) && !SCL);
endmodule

bind see_i2c_target see_i2c_target_properties #(.TWR_CYC(TWR_CYC)) i_props (
	.CLK(CLK), .RESET(RESET), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
	.SDA_OE(SDA_OE), .WRITE_PROTECT(WRITE_PROTECT), .BUSY(BUSY));
`default_nettype wire

// ===== tb/see_i2c_target_tb.sv
// Purpose: Self-checking bench for the serial EEPROM target.
// Assumes: Controller model owns SCL; the SDA wire is resolved here.
// Notes:   Short write cycle keeps the run brief but still outlasts a poll.
`timescale 1ns/1ns
`default_nettype none
`include "see_map.svh"

module see_i2c_target_tb
	import see_pkg::*;
;
	localparam int TWR = 128;
	localparam logic [127:0] SN = 128'h5A3C_96E1_0F2D_4B78_C3A5_1E69_D207_8FB4; // Value is arbitrary
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       wp = 1'b0;
	logic [2:0] pins = 3'h0;
	wire logic  scl;
	wire logic  ctl_oe;
	wire logic  sda;
	logic       dut_out;
	logic       dut_oe;
	logic       busy;
	int         n_mismatch = 0;
	int         n_tests = 0;
	integer     seed = 32'hD8E35629;
	see_byte_t  exp_mem [4096];

	always #50 clk = ~clk;

	// Open-drain data wire with pull-up
	assign sda = ~(ctl_oe | (dut_oe & ~dut_out));

	see_i2c_target #(.TWR_CYC(TWR), .SERIAL_NUMBER(SN)) i_dut (
		.CLK(clk), .RESET(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(dut_out), .SDA_OE(dut_oe),
		.ADDR_SELECT_BIT0(pins[0]), .ADDR_SELECT_BIT1(pins[1]), .ADDR_SELECT_BIT2(pins[2]),
		.WRITE_PROTECT(wp), .BUSY(busy));

	see_ctl_model i_ctl (.scl(scl), .sda_oe(ctl_oe), .sda(sda));

	task tally_and_finish();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp || $isunknown(seen)) begin
			n_mismatch++;
			$display("BAD %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// Expected byte: serial space wraps in 16, array by the shadow copy
	function automatic see_byte_t want(input logic [3:0] typ, input see_addr_t a);
		if (typ == `SEE_TYPE_SERIAL)
			return see_byte_t'(SN >> (8 * (15 - a[3:0])));
		return exp_mem[a];
	endfunction

	// Bounded wait on the write cycle flag
	task wait_busy(input logic lvl, input int lim);
		int c;
		c = 0;
		while (busy !== lvl && c < lim) begin
			@(posedge clk);
			c++;
		end
		chk("busy level", busy, lvl);
		if (busy !== lvl)
			tally_and_finish();
	endtask

	// Frames open just after a clock edge, never on it, so pins never race CLK
	task sync_start();
		@(posedge clk);
		#1;
		i_ctl.start();
	endtask

	task wr(input logic [3:0] typ, input see_addr_t a, input int n, input logic ok);
		logic      k;
		see_byte_t d;
		sync_start();
		i_ctl.byte_w({typ, pins, 1'b0}, k);
		chk("select ack", k, 1'b1);
		i_ctl.byte_w({4'h0, a[11:8]}, k);
		i_ctl.byte_w(a[7:0], k);
		for (int i = 0; i < n; i++) begin
			d = see_byte_t'($random(seed));
			i_ctl.byte_w(d, k);
			chk("data ack", k, ok);
			if (ok)
				exp_mem[{a[11:5], 5'(a[4:0] + i)}] = d;
		end
		i_ctl.stop();
		if (ok) begin
			wait_busy(1'b1, 20);
			sync_start();
			i_ctl.byte_w({typ, pins, 1'b0}, k);
			chk("poll ack", k, 1'b0);
			i_ctl.stop();
			wait_busy(1'b0, TWR + 10);
		end
	endtask

	// Random read, or current-address read when cur is set
	task rd(input logic [3:0] typ, input see_addr_t a, input int n, input logic cur);
		logic      k;
		see_byte_t d;
		sync_start();
		if (!cur) begin
			i_ctl.byte_w({typ, pins, 1'b0}, k);
			i_ctl.byte_w({4'h0, a[11:8]}, k);
			i_ctl.byte_w(a[7:0], k);
			i_ctl.start();
		end
		i_ctl.byte_w({typ, pins, 1'b1}, k);
		chk("read select ack", k, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_ctl.byte_r(i == n - 1, d);
			chk("read data", d, want(typ, see_addr_t'(a + i)));
		end
		i_ctl.stop();
	endtask

	// Main sequence
	initial begin
		logic      k;
		see_addr_t a;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		pins = 3'($random(seed));
		repeat (3) @(posedge clk);
		wr(`SEE_TYPE_ARRAY, 12'h003, 34, 1'b1);
		wr(`SEE_TYPE_ARRAY, 12'hFFF, 1, 1'b1);
		a = see_addr_t'($random(seed)) & 12'hFF3;
		wr(`SEE_TYPE_ARRAY, a, 5, 1'b1);
		$display("-- writes done");
		rd(`SEE_TYPE_ARRAY, 12'hFFF, 1, 1'b0);
		rd(`SEE_TYPE_ARRAY, 12'h000, 32, 1'b1);
		rd(`SEE_TYPE_ARRAY, a, 4, 1'b0);
		rd(`SEE_TYPE_ARRAY, see_addr_t'(a + 4), 1, 1'b1);
		$display("-- reads done");
		@(posedge clk) #1 wp = 1'b1;
		wr(`SEE_TYPE_ARRAY, 12'h010, 4, 1'b0);
		@(posedge clk) #1 wp = 1'b0;
		rd(`SEE_TYPE_ARRAY, 12'h010, 4, 1'b0);
		// Protect raised after an accepted byte but before the stop: nothing lands
		sync_start();
		i_ctl.byte_w({`SEE_TYPE_ARRAY, pins, 1'b0}, k);
		i_ctl.byte_w(8'h00, k);
		i_ctl.byte_w(8'h10, k);
		i_ctl.byte_w(~exp_mem[12'h010], k);
		chk("late protect ack", k, 1'b1);
		@(posedge clk) #1 wp = 1'b1;
		repeat (3) @(posedge clk);
		#1 i_ctl.stop();
		repeat (20) @(posedge clk);
		chk("late protect busy", busy, 1'b0);
		@(posedge clk) #1 wp = 1'b0;
		rd(`SEE_TYPE_ARRAY, 12'h010, 1, 1'b0);
		$display("-- protect done");
		rd(`SEE_TYPE_SERIAL, 12'h000, 16, 1'b0);
		wr(`SEE_TYPE_SERIAL, 12'h004, 2, 1'b0);
		rd(`SEE_TYPE_SERIAL, 12'h00E, 4, 1'b0);
		rd(`SEE_TYPE_ARRAY, 12'h004, 2, 1'b0);
		$display("-- serial number done");
		// Every identity, first with random pins, then with pins at pull-down level
		for (int p = 0; p < 2; p++) begin
			@(posedge clk) #1 pins = p ? 3'h0 : pins;
			repeat (3) @(posedge clk);
			for (int id = 0; id < 8; id++) begin
				sync_start();
				i_ctl.byte_w({`SEE_TYPE_ARRAY, 3'(id), 1'b0}, k);
				chk("identity ack", k, 8'(id == pins));
				i_ctl.stop();
			end
		end
		$display("-- identity done");
		tally_and_finish();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		$display("BAD watchdog: expected done, seen hang");
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
